// *** cpb_regs.svh ***
// constants for the cpu control and register bank block
// assumes a same-clock decoder and a one-cycle-latency memory port
`ifndef CPB_REGS_SVH
`define CPB_REGS_SVH
// ---------------------------------------------
// flags word layout
// ---------------------------------------------
`define CPB_FLG_IEN 3'd7
`define CPB_FLG_Z 3'd6
`define CPB_FLG_RBH 3'd5
`define CPB_FLG_HC 3'd4
`define CPB_FLG_RBL 3'd3
`define CPB_FLG_PRI 3'd1
`define CPB_FLG_CAR 3'd0
`define CPB_FLG_RST 8'h02
`define CPB_FLG_WMASK 8'hFB
// ---------------------------------------------
// memory map figures
// ---------------------------------------------
`define CPB_VEC_LO 16'h0000
`define CPB_VEC_HI 16'h0001
`define CPB_GPR_BASE 16'hFEE0
`define CPB_GPR_LAST 16'hFEFF
`define CPB_DSP_BASE 16'hFA58
`define CPB_DSP_LAST 16'hFA7F
`define CPB_DSP_N 6'd40
// ---------------------------------------------
// avalon byte offsets
// ---------------------------------------------
`define CPB_OFS_FLG 10'h000
`define CPB_OFS_SP 10'h004
`define CPB_OFS_PC 10'h008
`define CPB_OFS_STA 10'h00C
`define CPB_OFS_GPR 10'h080
`define CPB_OFS_DSP 10'h100
`endif

// *** cpb_pkg.sv ***
// types shared by the cpu control and register bank block
// assumes cpb_regs.svh carries the numeric constants
package cpb_pkg;
    // ---------------------------------------------
    // decoder commands
    // ---------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADV = 4'h1,
        OP_JMP = 4'h2,
        OP_PUSHF = 4'h3,
        OP_POPF = 4'h4,
        OP_RET = 4'h5,
        OP_IRET = 4'h6,
        OP_BRET = 4'h7,
        OP_MASK = 4'h8,
        OP_UNMASK = 4'h9,
        OP_SEL = 4'hA
    } cpb_op_e;
    // gray along vector fetch, run, push, pop
    typedef enum logic [2:0] {
        ST_VLO = 3'h0,
        ST_VHI = 3'h1,
        ST_VEND = 3'h3,
        ST_RUN = 3'h2,
        ST_PUSH = 3'h6,
        ST_POP0 = 3'h7,
        ST_POP1 = 3'h5,
        ST_POP2 = 3'h4
    } cpb_st_e;
    typedef struct packed {
        cpb_op_e op;
        logic [2:0] len;
        logic [15:0] target;
        logic [1:0] bank;
    } cpb_cmd_s;
    typedef struct packed {
        logic upd;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] res;
        logic cy_we;
        logic cy;
    } cpb_alu_s;
    typedef struct packed {
        logic we;
        logic pair;
        logic [2:0] idx;
        logic [15:0] wdata;
    } cpb_gpr_s;
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpb_mem_s;
    typedef struct packed {
        logic nmi;
        logic pend;
        logic masked;
        logic low;
    } cpb_irq_s;
endpackage

// *** cpb_core_regs.sv ***
// cpu control registers, register banks and display ram
// assumes decoder, memory and avalon master share clk_sys
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "cpb_regs.svh"
module cpb_core_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // avalon slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // decoder side
    input wire cpb_pkg::cpb_cmd_s cmd_i,
    output logic cmd_ready,
    input wire cpb_pkg::cpb_alu_s alu_i,
    input wire cpb_pkg::cpb_gpr_s gpr_i,
    output logic [15:0] gpr_rdata,
    input wire cpb_pkg::cpb_irq_s irq_i,
    output logic irq_accept,
    // memory port, read data one cycle after req
    output cpb_pkg::cpb_mem_s mem_o,
    input wire logic [7:0] mem_rdata,
    // state
    output logic [15:0] next_fetch_counter,
    output logic [7:0] processor_flags_word,
    output logic [15:0] stack_top_pointer
);
    // ---------------------------------------------
    // state
    // ---------------------------------------------
    cpb_pkg::cpb_st_e st_ff, nxt_st;
    logic [15:0] pc_ff;
    logic [7:0] flg_ff;
    logic [15:0] sp_ff;
    logic [7:0] push_ff;
    logic [1:0] popk_ff;
    logic ack_ff;
    logic [31:0] rd_ff;
    logic [15:0] grd_ff;
    logic [7:0] gpr_mem [0:31];
    logic [3:0] dsp_mem [0:39];
    logic av_req, av_wr, take, accept;
    logic is_gpr, is_dsp;
    logic [4:0] gpr_av;
    logic [5:0] dsp_av;
    logic [4:0] gpr_lo;
    logic [1:0] bank;
    logic do_pop;

    assign bank = {flg_ff[`CPB_FLG_RBH], flg_ff[`CPB_FLG_RBL]};
    assign next_fetch_counter = pc_ff;
    assign processor_flags_word = flg_ff;
    assign stack_top_pointer = sp_ff;
    assign gpr_rdata = grd_ff;
    assign avs_readdata = rd_ff;

    // ---------------------------------------------
    // avalon decode
    // ---------------------------------------------
    // a bus access waits for a ready cycle with no command or accept; core commands stall only in its ack cycle
    assign av_req = avs_read | avs_write;
    assign avs_waitrequest = av_req & ~ack_ff;
    assign av_wr = avs_write & ack_ff;
    assign is_gpr = avs_address[9:7] == 3'h1;
    assign gpr_av = avs_address[6:2];
    assign dsp_av = avs_address[7:2];
    assign is_dsp = (avs_address[9:8] == 2'h1) && (dsp_av < `CPB_DSP_N);
    assign cmd_ready = (st_ff == cpb_pkg::ST_RUN) & ~ack_ff;
    assign take = cmd_ready & (cmd_i.op != cpb_pkg::OP_NOP);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= av_req & ~ack_ff & cmd_ready & ~take & ~accept;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_ff <= 32'h00000000;
        end else if (av_req & ~ack_ff) begin
            rd_ff <= 32'h00000000;
            if (avs_address == `CPB_OFS_FLG) begin
                rd_ff[7:0] <= flg_ff;
            end else if (avs_address == `CPB_OFS_SP) begin
                rd_ff[15:0] <= sp_ff;
            end else if (avs_address == `CPB_OFS_PC) begin
                rd_ff[15:0] <= pc_ff;
            end else if (avs_address == `CPB_OFS_STA) begin
                rd_ff[2:0] <= st_ff;
            end else if (is_gpr && avs_address[1:0] == 2'h0) begin
                rd_ff[7:0] <= gpr_mem[gpr_av];
            end else if (is_dsp && avs_address[1:0] == 2'h0) begin
                rd_ff[3:0] <= dsp_mem[dsp_av];
            end
        end
    end

    // ---------------------------------------------
    // interrupt acceptance
    // ---------------------------------------------
    // nmi bypasses the enable; low priority needs the priority flag set
    assign accept = (st_ff == cpb_pkg::ST_RUN) & ~ack_ff & ~take
        & (irq_i.nmi
        | (flg_ff[`CPB_FLG_IEN] & irq_i.pend & ~irq_i.masked
        & (flg_ff[`CPB_FLG_PRI] | ~irq_i.low)));
    assign irq_accept = accept;

    // ---------------------------------------------
    // sequencer
    // ---------------------------------------------
    assign do_pop = take & ((cmd_i.op == cpb_pkg::OP_POPF)
        | (cmd_i.op == cpb_pkg::OP_RET) | (cmd_i.op == cpb_pkg::OP_IRET)
        | (cmd_i.op == cpb_pkg::OP_BRET));

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            cpb_pkg::ST_VLO: nxt_st = cpb_pkg::ST_VHI;
            cpb_pkg::ST_VHI: nxt_st = cpb_pkg::ST_VEND;
            cpb_pkg::ST_VEND: nxt_st = cpb_pkg::ST_RUN;
            cpb_pkg::ST_RUN: begin
                if (do_pop) begin
                    nxt_st = cpb_pkg::ST_POP0;
                end else if (accept | (take & cmd_i.op == cpb_pkg::OP_PUSHF)) begin
                    nxt_st = cpb_pkg::ST_PUSH;
                end
            end
            cpb_pkg::ST_PUSH: nxt_st = cpb_pkg::ST_RUN;
            cpb_pkg::ST_POP0: begin
                nxt_st = (popk_ff == 2'h0) ? cpb_pkg::ST_RUN : cpb_pkg::ST_POP1;
            end
            cpb_pkg::ST_POP1: begin
                nxt_st = (popk_ff == 2'h2) ? cpb_pkg::ST_POP2 : cpb_pkg::ST_RUN;
            end
            cpb_pkg::ST_POP2: nxt_st = cpb_pkg::ST_RUN;
            default: nxt_st = cpb_pkg::ST_VLO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= cpb_pkg::ST_VLO;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pop kind: 0 flags only, 1 counter, 2 counter then flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            popk_ff <= 2'h0;
        end else if (do_pop) begin
            if (cmd_i.op == cpb_pkg::OP_POPF) begin
                popk_ff <= 2'h0;
            end else if (cmd_i.op == cpb_pkg::OP_RET) begin
                popk_ff <= 2'h1;
            end else begin
                popk_ff <= 2'h2;
            end
        end
    end

    // ---------------------------------------------
    // memory port
    // ---------------------------------------------
    always_comb begin
        mem_o = '0;
        case (st_ff)
            cpb_pkg::ST_VLO: begin
                mem_o.req = 1'b1;
                mem_o.addr = `CPB_VEC_LO;
            end
            cpb_pkg::ST_VHI: begin
                mem_o.req = 1'b1;
                mem_o.addr = `CPB_VEC_HI;
            end
            cpb_pkg::ST_RUN: begin
                mem_o.req = do_pop;
                mem_o.addr = sp_ff;
            end
            cpb_pkg::ST_PUSH: begin
                mem_o.req = 1'b1;
                mem_o.we = 1'b1;
                mem_o.addr = sp_ff;
                mem_o.wdata = push_ff;
            end
            cpb_pkg::ST_POP0: begin
                mem_o.req = popk_ff != 2'h0;
                mem_o.addr = sp_ff;
            end
            cpb_pkg::ST_POP1: begin
                mem_o.req = popk_ff == 2'h2;
                mem_o.addr = sp_ff;
            end
            default: mem_o = '0;
        endcase
    end

    // ---------------------------------------------
    // next fetch counter
    // ---------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_ff <= 16'h0000;
        end else if (st_ff == cpb_pkg::ST_VHI) begin
            pc_ff[7:0] <= mem_rdata;
        end else if (st_ff == cpb_pkg::ST_VEND) begin
            pc_ff[15:8] <= mem_rdata;
        end else if (st_ff == cpb_pkg::ST_POP0 && popk_ff != 2'h0) begin
            pc_ff[7:0] <= mem_rdata;
        end else if (st_ff == cpb_pkg::ST_POP1) begin
            pc_ff[15:8] <= mem_rdata;
        end else if (av_wr && avs_address == `CPB_OFS_PC) begin
            pc_ff <= avs_writedata[15:0];
        end else if (take && cmd_i.op == cpb_pkg::OP_ADV) begin
            pc_ff <= pc_ff + {13'h0000, cmd_i.len};
        end else if (take && cmd_i.op == cpb_pkg::OP_JMP) begin
            pc_ff <= cmd_i.target;
        end
    end

    // ---------------------------------------------
    // stack pointer
    // ---------------------------------------------
    // no reset value: software must load it first
    always_ff @(posedge clk_sys) begin
        if (av_wr && avs_address == `CPB_OFS_SP) begin
            sp_ff <= avs_writedata[15:0];
        end else if (accept | (take & cmd_i.op == cpb_pkg::OP_PUSHF)) begin
            sp_ff <= sp_ff - 16'h0001;
        end else if (do_pop) begin
            sp_ff <= sp_ff + 16'h0001;
        end else if ((st_ff == cpb_pkg::ST_POP0 && popk_ff != 2'h0)
            || (st_ff == cpb_pkg::ST_POP1 && popk_ff == 2'h2)) begin
            sp_ff <= sp_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            push_ff <= 8'h00;
        end else if (accept | take) begin
            push_ff <= flg_ff;
        end
    end

    // ---------------------------------------------
    // flags word
    // ---------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flg_ff <= `CPB_FLG_RST;
        end else if (st_ff == cpb_pkg::ST_POP0 && popk_ff == 2'h0) begin
            flg_ff <= mem_rdata;
        end else if (st_ff == cpb_pkg::ST_POP2) begin
            flg_ff <= mem_rdata;
        end else if (av_wr && avs_address == `CPB_OFS_FLG) begin
            flg_ff <= avs_writedata[7:0] & `CPB_FLG_WMASK;
        end else if (accept) begin
            flg_ff[`CPB_FLG_IEN] <= 1'b0;
            if (!irq_i.nmi && !irq_i.low) begin
                flg_ff[`CPB_FLG_PRI] <= 1'b0;
            end
        end else if (take && cmd_i.op == cpb_pkg::OP_MASK) begin
            flg_ff[`CPB_FLG_IEN] <= 1'b0;
        end else if (take && cmd_i.op == cpb_pkg::OP_UNMASK) begin
            flg_ff[`CPB_FLG_IEN] <= 1'b1;
        end else if (take && cmd_i.op == cpb_pkg::OP_SEL) begin
            flg_ff[`CPB_FLG_RBH] <= cmd_i.bank[1];
            flg_ff[`CPB_FLG_RBL] <= cmd_i.bank[0];
        end else if (cmd_ready && !accept) begin
            // alu flags move in ready cycles with no accept, mask, unmask or bank select op
            if (alu_i.upd) begin
                flg_ff[`CPB_FLG_Z] <= alu_i.res == 8'h00;
                flg_ff[`CPB_FLG_HC] <= alu_i.a[4] ^ alu_i.b[4] ^ alu_i.res[4];
            end
            if (alu_i.cy_we) begin
                flg_ff[`CPB_FLG_CAR] <= alu_i.cy;
            end
        end
    end

    // ---------------------------------------------
    // register banks and display ram
    // ---------------------------------------------
    assign gpr_lo = {bank, gpr_i.idx[2:1], gpr_i.pair ? 1'b0 : gpr_i.idx[0]};

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_gpr
            always_ff @(posedge clk_sys) begin
                if (gpr_i.we && cmd_ready && gpr_lo == 5'(gi)) begin
                    gpr_mem[gi] <= gpr_i.wdata[7:0];
                end else if (gpr_i.we && cmd_ready && gpr_i.pair
                    && {gpr_lo[4:1], 1'b1} == 5'(gi)) begin
                    gpr_mem[gi] <= gpr_i.wdata[15:8];
                end else if (av_wr && is_gpr && gpr_av == 5'(gi)) begin
                    gpr_mem[gi] <= avs_writedata[7:0];
                end
            end
        end
        for (gi = 0; gi < 40; gi = gi + 1) begin : g_dsp
            always_ff @(posedge clk_sys) begin
                if (av_wr && is_dsp && dsp_av == 6'(gi)) begin
                    dsp_mem[gi] <= avs_writedata[3:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            grd_ff <= 16'h0000;
        end else begin
            grd_ff[7:0] <= gpr_mem[gpr_lo];
            grd_ff[15:8] <= gpr_i.pair ? gpr_mem[{gpr_lo[4:1], 1'b1}] : 8'h00;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    logic [7:0] mdat_ff;
    always_ff @(posedge clk_sys) begin
        mdat_ff <= mem_rdata;
    end

    sequence s_vec_fetch;
        st_ff == cpb_pkg::ST_VLO ##1 st_ff == cpb_pkg::ST_VHI
            ##1 st_ff == cpb_pkg::ST_VEND;
    endsequence

    chk_vec_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_vec_fetch |=> pc_ff == {mdat_ff, $past(mem_rdata, 2)})
        else $error("counter not loaded from vector");

    chk_vec_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff == cpb_pkg::ST_VHI |-> mem_o.req && mem_o.addr == `CPB_VEC_HI)
        else $error("vector high byte address wrong");

    chk_flags_rst: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> flg_ff == `CPB_FLG_RST)
        else $error("flags reset value wrong");

    chk_pc_adv: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && cmd_i.op == cpb_pkg::OP_ADV |=> pc_ff == $past(pc_ff) + $past(cmd_i.len))
        else $error("counter advance wrong");

    chk_nmi_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !flg_ff[`CPB_FLG_IEN] |-> irq_i.nmi)
        else $error("maskable accepted while disabled");

    chk_low_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !irq_i.nmi && !flg_ff[`CPB_FLG_PRI] |-> !irq_i.low)
        else $error("low priority accepted");

    chk_accept_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept |=> !flg_ff[`CPB_FLG_IEN] && mem_o.we && mem_o.wdata == $past(flg_ff))
        else $error("accept did not clear enable or push flags");

    chk_push_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff == cpb_pkg::ST_PUSH |-> mem_o.addr == $past(sp_ff) - 16'h0001)
        else $error("stack not pre-decremented");

    chk_iret_ord: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && cmd_i.op == cpb_pkg::OP_IRET |-> mem_o.addr == sp_ff
        ##1 mem_o.addr == $past(sp_ff) + 16'h0001
        ##1 mem_o.addr == $past(sp_ff, 2) + 16'h0002 ##2 sp_ff == $past(sp_ff, 4) + 16'h0003)
        else $error("return frame order wrong");

    chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_ready && !accept && !take && alu_i.upd
        |=> flg_ff[`CPB_FLG_Z] == ($past(alu_i.res) == 8'h00))
        else $error("zero flag wrong");

    chk_bank_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && cmd_i.op == cpb_pkg::OP_SEL |=> bank == $past(cmd_i.bank))
        else $error("bank select not stored");

    chk_bus_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        av_req && !ack_ff && cmd_ready && !take && !accept |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule

// *** tb_top.sv ***
// self-checking bench for the cpu control and register bank block
// assumes cpb_pkg and cpb_regs.svh are compiled first; bench models the memory port
`timescale 1ns/1ps
`include "cpb_regs.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    cpb_pkg::cpb_cmd_s cmd_i = '0;
    logic cmd_ready;
    cpb_pkg::cpb_alu_s alu_i = '0;
    cpb_pkg::cpb_gpr_s gpr_i = '0;
    logic [15:0] gpr_rdata;
    cpb_pkg::cpb_irq_s irq_i = '0;
    logic irq_accept;
    cpb_pkg::cpb_mem_s mem_o;
    logic [7:0] mem_rdata = 8'h00;
    logic [15:0] next_fetch_counter;
    logic [7:0] processor_flags_word;
    logic [15:0] stack_top_pointer;
    logic [7:0] mem [0:65535];
    logic [31:0] rd;
    logic got;
    logic [7:0] f;
    int fail_count = 0;
    int compares = 0;

    always #2.5 clk_sys = ~clk_sys;

    cpb_core_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_i(cmd_i),
        .cmd_ready(cmd_ready), .alu_i(alu_i), .gpr_i(gpr_i), .gpr_rdata(gpr_rdata),
        .irq_i(irq_i), .irq_accept(irq_accept), .mem_o(mem_o), .mem_rdata(mem_rdata),
        .next_fetch_counter(next_fetch_counter), .processor_flags_word(processor_flags_word),
        .stack_top_pointer(stack_top_pointer));

    // ---------------------------------------------
    // memory port model
    // ---------------------------------------------
    // idle data toggles so a stale byte is never mistaken for an answer
    always @(posedge clk_sys) begin
        if (mem_o.req && !mem_o.we) mem_rdata <= mem[mem_o.addr];
        else mem_rdata <= ~mem_rdata;
        if (mem_o.req && mem_o.we) mem[mem_o.addr] <= mem_o.wdata;
    end

    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) begin
            fail_count++;
            $display("Error cmd_ready timeout");
        end
    endtask
    task automatic do_cmd(cpb_pkg::cpb_op_e op, logic [2:0] len, logic [15:0] tg, logic [1:0] bk);
        wait_ready();
        @(posedge clk_sys);
        cmd_i <= {op, len, tg, bk};
        @(posedge clk_sys);
        cmd_i <= '0;
        wait_ready();
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic av(logic we, logic [9:0] adr, logic [31:0] wd);
        @(posedge clk_sys);
        avs_write <= we;
        avs_read <= !we;
        avs_address <= adr;
        avs_writedata <= wd;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic alu(logic [7:0] a, logic [7:0] b, logic [7:0] r, logic cyw, logic cy);
        @(posedge clk_sys);
        alu_i <= {1'b1, a, b, r, cyw, cy};
        @(posedge clk_sys);
        alu_i <= '0;
        @(negedge clk_sys);
    endtask
    task automatic irq_try(cpb_pkg::cpb_irq_s v);
        int n;
        n = 0;
        got = 1'b0;
        @(posedge clk_sys);
        irq_i <= v;
        while (!got && n < 6) begin
            @(negedge clk_sys);
            got = (irq_accept === 1'b1);
            n++;
        end
        @(posedge clk_sys);
        irq_i <= '0;
        wait_ready();
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset();
        repeat (5) @(posedge clk_sys);
        chk("flags in reset", processor_flags_word, 32'h02);
        rst_n <= 1'b1;
        wait_ready();
        chk("counter from vector", next_fetch_counter, 32'h1234);
        $display("test reset done");
    endtask
    task automatic t_flow();
        do_cmd(cpb_pkg::OP_ADV, 3'd3, 16'h0, 2'd0);
        chk("counter advance", next_fetch_counter, 32'h1237);
        do_cmd(cpb_pkg::OP_JMP, 3'd0, 16'hFFFE, 2'd0);
        chk("branch target", next_fetch_counter, 32'hFFFE);
        do_cmd(cpb_pkg::OP_ADV, 3'd3, 16'h0, 2'd0);
        chk("counter wrap", next_fetch_counter, 32'h0001);
        $display("test flow done");
    endtask
    task automatic t_flags();
        do_cmd(cpb_pkg::OP_UNMASK, 3'd0, 16'h0, 2'd0);
        chk("enable set", processor_flags_word[`CPB_FLG_IEN], 32'h1);
        do_cmd(cpb_pkg::OP_MASK, 3'd0, 16'h0, 2'd0);
        chk("enable clear", processor_flags_word[`CPB_FLG_IEN], 32'h0);
        for (int b = 3; b >= 0; b--) begin
            do_cmd(cpb_pkg::OP_SEL, 3'd0, 16'h0, b[1:0]);
            chk("bank", {processor_flags_word[5], processor_flags_word[3]}, b);
        end
        alu(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        chk("zero and half", {processor_flags_word[6], processor_flags_word[4]}, 32'h2);
        alu(8'h08, 8'h08, 8'h10, 1'b1, 1'b1);
        chk("half carry", processor_flags_word & 8'h51, 32'h11);
        alu(8'h10, 8'h01, 8'h11, 1'b1, 1'b0);
        chk("no carries", processor_flags_word & 8'h51, 32'h00);
        $display("test flags done");
    endtask
    task automatic t_stack();
        cpb_pkg::cpb_op_e ops [2];
        ops = '{cpb_pkg::OP_IRET, cpb_pkg::OP_BRET};
        av(1'b1, `CPB_OFS_SP, 32'hFE40);
        f = processor_flags_word;
        do_cmd(cpb_pkg::OP_PUSHF, 3'd0, 16'h0, 2'd0);
        chk("sp predec", stack_top_pointer, 32'hFE3F);
        chk("pushed flags", mem[16'hFE3F], f);
        foreach (ops[i]) begin
            av(1'b1, `CPB_OFS_SP, 32'hFE40);
            mem[16'hFE40] = 8'hCD;
            mem[16'hFE41] = 8'hAB;
            mem[16'hFE42] = 8'h89 ^ {7'h0, i[0]};
            do_cmd(ops[i], 3'd0, 16'h0, 2'd0);
            chk("pop counter", next_fetch_counter, 32'hABCD);
            chk("pop flags", processor_flags_word, 8'h89 ^ {7'h0, i[0]});
            chk("sp postinc", stack_top_pointer, 32'hFE43);
        end
        av(1'b1, `CPB_OFS_SP, 32'hFE40);
        mem[16'hFE41] = 8'h5A;
        mem[16'hFE42] = 8'h41;
        do_cmd(cpb_pkg::OP_RET, 3'd0, 16'h0, 2'd0);
        chk("ret counter", next_fetch_counter, 32'h5ACD);
        chk("ret sp", stack_top_pointer, 32'hFE42);
        do_cmd(cpb_pkg::OP_POPF, 3'd0, 16'h0, 2'd0);
        chk("popped flags", processor_flags_word, 32'h41);
        chk("flags pop sp", stack_top_pointer, 32'hFE43);
        $display("test stack done");
    endtask
    task automatic t_gpr();
        do_cmd(cpb_pkg::OP_SEL, 3'd0, 16'h0, 2'd2);
        @(posedge clk_sys);
        gpr_i <= {1'b1, 1'b1, 3'd2, 16'hBEEF};
        @(posedge clk_sys);
        gpr_i <= {1'b0, 1'b1, 3'd2, 16'h0000};
        repeat (2) @(posedge clk_sys);
        chk("pair read", gpr_rdata, 32'hBEEF);
        av(1'b0, `CPB_OFS_GPR + 10'h048, 32'h0);
        chk("bank2 low", rd, 32'hEF);
        av(1'b0, `CPB_OFS_GPR + 10'h04C, 32'h0);
        chk("bank2 high", rd, 32'hBE);
        av(1'b1, `CPB_OFS_DSP + 10'h09C, 32'h5);
        av(1'b0, `CPB_OFS_DSP + 10'h09C, 32'h0);
        chk("display ram", rd, 32'h5);
        av(1'b0, 10'h3F0, 32'h0);
        chk("unmapped", rd, 32'h0);
        av(1'b1, `CPB_OFS_FLG, 32'hFF);
        av(1'b0, `CPB_OFS_FLG, 32'h0);
        chk("flags write", rd, 32'hFB);
        $display("test gpr done");
    endtask
    task automatic t_irq();
        av(1'b1, `CPB_OFS_SP, 32'hFE40);
        do_cmd(cpb_pkg::OP_MASK, 3'd0, 16'h0, 2'd0);
        irq_try(4'b0100);
        chk("masked by enable", got, 32'h0);
        f = processor_flags_word;
        irq_try(4'b1100);
        chk("nmi accept", got, 32'h1);
        chk("nmi push", mem[16'hFE3F], f);
        do_cmd(cpb_pkg::OP_UNMASK, 3'd0, 16'h0, 2'd0);
        irq_try(4'b0110);
        chk("source mask", got, 32'h0);
        irq_try(4'b0101);
        chk("low with priority set", got, 32'h1);
        do_cmd(cpb_pkg::OP_UNMASK, 3'd0, 16'h0, 2'd0);
        irq_try(4'b0100);
        chk("high accept", got, 32'h1);
        chk("enable and priority cleared", processor_flags_word & 8'h82, 32'h0);
        do_cmd(cpb_pkg::OP_UNMASK, 3'd0, 16'h0, 2'd0);
        irq_try(4'b0101);
        chk("low refused", got, 32'h0);
        $display("test irq done");
    endtask

    initial begin
        mem[16'h0000] = 8'h34;
        mem[16'h0001] = 8'h12;
        t_reset();
        t_flow();
        t_flags();
        t_stack();
        t_gpr();
        t_irq();
        close_out();
    end

    // watchdog well beyond the roughly 160 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end
endmodule
